/* rtl/wcd_datapath.v */
// word conversion datapath: binary/time to bcd and digit decoder
// Functional notes
// - 16-bit source above 270f: no conversion, result word kept.
// - 16-bit result is the equal bcd value; source never touched.
// - error flag set when 16-bit source above 270f.
// - zero flag follows each produced result: set if zero.
// - 32-bit source above 05f5e0ff: no conversion, both words kept.
// - 32-bit source from two words, eight bcd digits to two words.
// - time source: seconds bits 0-7, minutes 8-15, hours next word.
// - total seconds written as bcd to two result words.
// - error when time source not bcd or seconds/minutes above 59.
// - error when source or result pair crosses a data area.
// - time result: seconds bits 0-7, minutes 8-15, hours next word.
// - error when seconds source not bcd or out of range.
// - decoder does nothing while execution condition is off.
// - each source digit 0-15 sets that bit, one word per digit.
// - start digit and digit count come from the designator.
// - designator 0001 decodes one digit starting at digit 1.
// - digits past digit 3 wrap back to digit 0 of the source.
// - error on undefined designator or result words out of area.
// - error on any faulty indirectly addressed word.
`timescale 1ns/1ps
`include "wcd_defines.vh"
module wcd_datapath (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        opStart,
   input  wire        execCond,
   input  wire [2:0]  opCode,
   input  wire [15:0] srcWord0,
   input  wire [15:0] srcWord1,
   input  wire [15:0] digitDesignator,
   input  wire        srcAreaSame,
   input  wire        dstAreaSame,
   input  wire [2:0]  resultRoom,
   input  wire        indirectFault,
   output reg         opDone,
   output reg  [3:0]  resWrite,
   output reg  [15:0] resWord0,
   output reg  [15:0] resWord1,
   output reg  [15:0] resWord2,
   output reg  [15:0] resWord3,
   output reg         errorFlag,
   output reg         zeroFlag
);
   reg         rstMeta_n;
   reg         rstSync_n;

   wire [31:0] convBcd;
   wire [31:0] hoursBcd;
   reg  [31:0] convBin;

   reg         srcIsBcd;
   reg  [26:0] hmsSeconds;
   reg  [26:0] secValue;
   reg  [26:0] hoursBin;
   reg  [26:0] remSec;
   reg  [26:0] minBin;
   reg  [26:0] secBin;
   reg  [7:0]  minBcd;
   reg  [7:0]  secBcd;

   wire [1:0]  diStart;
   wire [3:0]  diCountM1;
   wire        diUndefined;
   wire [2:0]  diCount;
   wire [63:0] onehotWords;

   reg         next_done;
   reg  [3:0]  next_write;
   reg  [15:0] next_res0;
   reg  [15:0] next_res1;
   reg  [15:0] next_res2;
   reg  [15:0] next_res3;
   reg         next_error;
   reg         next_zero;

   // true when every nibble of a word is a decimal digit
   function isBcd16;
      input [15:0] w;
      begin
         isBcd16 = (w[3:0] < 4'ha) && (w[7:4] < 4'ha) &&
                   (w[11:8] < 4'ha) && (w[15:12] < 4'ha);
      end
   endfunction

   // two bcd digits to binary
   function [26:0] bcd2Bin;
      input [7:0] d;
      begin
         bcd2Bin = {23'h0, d[7:4]} * 27'ha + {23'h0, d[3:0]};
      end
   endfunction

   // four bcd digits to binary
   function [26:0] bcd4Bin;
      input [15:0] d;
      begin
         bcd4Bin = bcd2Bin(d[15:8]) * 27'h64 + bcd2Bin(d[7:0]);
      end
   endfunction

   // binary below 100 to two bcd digits
   function [7:0] bin2Bcd;
      input [26:0] v;
      reg   [26:0] tens;
      reg   [26:0] ones;
      begin
         tens = v / 27'ha;
         ones = v - tens * 27'ha;
         bin2Bcd = {tens[3:0], ones[3:0]};
      end
   endfunction

   // reset released through two flip-flops
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   // time arithmetic for both directions
   always @* begin
      srcIsBcd   = isBcd16(srcWord0) && isBcd16(srcWord1);
      hmsSeconds = bcd4Bin(srcWord1) * `WCD_SEC_PER_HOUR
                 + bcd2Bin(srcWord0[`WCD_MIN_LSB +: 8])
                   * `WCD_SEC_PER_MIN
                 + bcd2Bin(srcWord0[`WCD_SEC_LSB +: 8]);
      secValue   = bcd4Bin(srcWord1) * 27'h2710 + bcd4Bin(srcWord0);
      hoursBin   = secValue / `WCD_SEC_PER_HOUR;
      remSec     = secValue - hoursBin * `WCD_SEC_PER_HOUR;
      minBin     = remSec / `WCD_SEC_PER_MIN;
      secBin     = remSec - minBin * `WCD_SEC_PER_MIN;
      minBcd     = bin2Bcd(minBin);
      secBcd     = bin2Bcd(secBin);
   end

   // binary value fed to the shared bcd converter
   always @* begin
      case (opCode)
         `WCD_OP_BIN16:   convBin = {16'h0, srcWord0};
         `WCD_OP_BIN32:   convBin = {srcWord1, srcWord0};
         `WCD_OP_HMS2SEC: convBin = {5'h0, hmsSeconds};
         default:         convBin = {16'h0, srcWord0};
      endcase
   end

   wcd_bin_to_bcd convUnit (
      .binIn  (convBin),
      .bcdOut (convBcd)
   );

   // hours of the seconds-to-time result
   wcd_bin_to_bcd hoursUnit (
      .binIn  ({5'h0, hoursBin}),
      .bcdOut (hoursBcd)
   );

   // designator fields
   assign diStart     = digitDesignator[`WCD_DI_START_LSB +: 2];
   assign diCountM1   = digitDesignator[`WCD_DI_COUNT_LSB +: 4];
   assign diUndefined =
      (digitDesignator[`WCD_DI_START_LSB +: 4] > `WCD_DI_DIGIT_MAX) ||
      (diCountM1 > `WCD_DI_DIGIT_MAX);
   assign diCount     = {1'b0, diCountM1[1:0]} + 3'h1;

   // one decoded word per result slot
   genvar slot;
   generate
      for (slot = 0; slot < 4; slot = slot + 1) begin : decodeSlot
         wire [1:0] digIdx;
         wire [3:0] digVal;
         assign digIdx = diStart + slot[1:0];
         assign digVal = srcWord0[4*digIdx +: 4];
         assign onehotWords[16*slot +: 16] =
            16'h0001 << digVal;
      end
   endgenerate

   // operation result and flag selection
   always @* begin
      next_done  = 1'b0;
      next_write = 4'h0;
      next_res0  = resWord0;
      next_res1  = resWord1;
      next_res2  = resWord2;
      next_res3  = resWord3;
      next_error = errorFlag;
      next_zero  = zeroFlag;
      if (opStart) begin
         next_done = 1'b1;
         if (execCond) begin
            next_error = 1'b0;
            case (opCode)
               `WCD_OP_BIN16: begin
                  if (indirectFault) begin
                     next_error = 1'b1;
                  end else if (srcWord0 > `WCD_BIN16_MAX) begin
                     next_error = 1'b1;
                  end else begin
                     next_res0  = convBcd[15:0];
                     next_write = 4'h1;
                     next_zero  = (convBcd[15:0] == 16'h0);
                  end
               end
               `WCD_OP_BIN32: begin
                  if (indirectFault) begin
                     next_error = 1'b1;
                  end else if ({srcWord1, srcWord0} > `WCD_BIN32_MAX)
                  begin
                     next_error = 1'b1;
                  end else begin
                     next_res0  = convBcd[15:0];
                     next_res1  = convBcd[31:16];
                     next_write = 4'h3;
                     next_zero  = (convBcd == 32'h0);
                  end
               end
               `WCD_OP_HMS2SEC: begin
                  if (indirectFault) begin
                     next_error = 1'b1;
                  end else if (!srcAreaSame || !dstAreaSame) begin
                     next_error = 1'b1;
                  end else if (!srcIsBcd ||
                     srcWord0[`WCD_SEC_LSB +: 8] > `WCD_MINSEC_MAX ||
                     srcWord0[`WCD_MIN_LSB +: 8] > `WCD_MINSEC_MAX)
                  begin
                     next_error = 1'b1;
                  end else begin
                     next_res0  = convBcd[15:0];
                     next_res1  = convBcd[31:16];
                     next_write = 4'h3;
                     next_zero  = (convBcd == 32'h0);
                  end
               end
               `WCD_OP_SEC2HMS: begin
                  if (indirectFault) begin
                     next_error = 1'b1;
                  end else if (!srcAreaSame || !dstAreaSame) begin
                     next_error = 1'b1;
                  end else if (!srcIsBcd ||
                     secValue > `WCD_SEC_MAX) begin
                     next_error = 1'b1;
                  end else begin
                     next_res0  = {minBcd, secBcd};
                     next_res1  = hoursBcd[15:0];
                     next_write = 4'h3;
                     next_zero  = (secValue == 27'h0);
                  end
               end
               `WCD_OP_ONEHOT: begin
                  if (indirectFault) begin
                     next_error = 1'b1;
                  end else if (diUndefined ||
                     diCount > resultRoom) begin
                     next_error = 1'b1;
                  end else begin
                     next_res0  = onehotWords[15:0];
                     next_res1  = onehotWords[31:16];
                     next_res2  = onehotWords[47:32];
                     next_res3  = onehotWords[63:48];
                     next_write = (4'h1 << diCount) - 4'h1;
                     next_zero  = 1'b0;
                  end
               end
               default: begin
                  next_error = 1'b1;
               end
            endcase
         end
      end
   end

   // registered results, write strobes and flags
   always @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         opDone    <= 1'b0;
         resWrite  <= 4'h0;
         resWord0  <= `WCD_RES_RESET;
         resWord1  <= `WCD_RES_RESET;
         resWord2  <= `WCD_RES_RESET;
         resWord3  <= `WCD_RES_RESET;
         errorFlag <= `WCD_FLAG_RESET;
         zeroFlag  <= `WCD_FLAG_RESET;
      end else begin
         opDone    <= next_done;
         resWrite  <= next_write;
         resWord0  <= next_res0;
         resWord1  <= next_res1;
         resWord2  <= next_res2;
         resWord3  <= next_res3;
         errorFlag <= next_error;
         zeroFlag  <= next_zero;
      end
   end
endmodule // wcd_datapath

/* rtl/wcd_defines.vh */
// constants of the word conversion datapath
`ifndef WCD_DEFINES_VH
`define WCD_DEFINES_VH

// operation codes on opCode
`define WCD_OP_BIN16      3'h0
`define WCD_OP_BIN32      3'h1
`define WCD_OP_HMS2SEC    3'h2
`define WCD_OP_SEC2HMS    3'h3
`define WCD_OP_ONEHOT     3'h4

// source limits
`define WCD_BIN16_MAX     16'h270f
`define WCD_BIN32_MAX     32'h05f5e0ff
`define WCD_SEC_MAX       27'h22550ff
`define WCD_MINSEC_MAX    8'h59

// time factors
`define WCD_SEC_PER_HOUR  27'he10
`define WCD_SEC_PER_MIN   27'h3c

// field positions of the first time word
`define WCD_SEC_LSB       0
`define WCD_MIN_LSB       8

// digit designator fields
`define WCD_DI_START_LSB  0
`define WCD_DI_COUNT_LSB  4
`define WCD_DI_DIGIT_MAX  4'h3

// reset values
`define WCD_RES_RESET     16'h0000
`define WCD_FLAG_RESET    1'b0

`endif

/* rtl/wcd_bin_to_bcd.v */
// binary to eight-digit bcd converter, combinational
`timescale 1ns/1ps
module wcd_bin_to_bcd (
   input  wire [31:0] binIn,
   output reg  [31:0] bcdOut
);
   integer bitIdx;
   integer digIdx;
   reg     [63:0] work;

   // shift-and-add-three over all input bits
   always @* begin
      work = {32'h0, binIn};
      for (bitIdx = 0; bitIdx < 32; bitIdx = bitIdx + 1) begin
         for (digIdx = 0; digIdx < 8; digIdx = digIdx + 1) begin
            if (work[32 + 4*digIdx +: 4] > 4'h4) begin
               work[32 + 4*digIdx +: 4] =
                  work[32 + 4*digIdx +: 4] + 4'h3;
            end
         end
         work = {work[62:0], 1'b0};
      end
      bcdOut = work[63:32];
   end
endmodule // wcd_bin_to_bcd

/* sim/wcd_monitor.sv */
// port checker of the word conversion datapath
`timescale 1ns/1ps
module wcd_monitor (
   input wire        core_clk,
   input wire        rst_n,
   input wire        opStart,
   input wire        execCond,
   input wire [2:0]  opCode,
   input wire [15:0] srcWord0,
   input wire [15:0] srcWord1,
   input wire [15:0] digitDesignator,
   input wire        srcAreaSame,
   input wire        dstAreaSame,
   input wire [2:0]  resultRoom,
   input wire        indirectFault,
   input wire        opDone,
   input wire [3:0]  resWrite,
   input wire [15:0] resWord0,
   input wire [15:0] resWord1,
   input wire [15:0] resWord2,
   input wire [15:0] resWord3,
   input wire        errorFlag,
   input wire        zeroFlag
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // request that executes with clean operands
   wire go = opStart && execCond && !indirectFault;
   wire diBad = digitDesignator[3:0] > 4'h3 || digitDesignator[7:4] > 4'h3;

   done_next_a: assert property (opStart |=> opDone)
      else $error("no answer one cycle after request");
   cond_off_a: assert property (opStart && !execCond |=>
      resWrite == 4'h0 && $stable(errorFlag) && $stable(zeroFlag))
      else $error("idle request changed state");
   bin16_limit_a: assert property (go && opCode == 3'h0 &&
      srcWord0 > 16'h270f |=> errorFlag && resWrite == 4'h0)
      else $error("16-bit source above limit not refused");
   bin16_zero_a: assert property (go && opCode == 3'h0 &&
      srcWord0 <= 16'h270f |=> resWrite == 4'h1 && !errorFlag &&
      zeroFlag == ($past(srcWord0) == 16'h0))
      else $error("16-bit result write or zero status wrong");
   bin32_limit_a: assert property (go && opCode == 3'h1 &&
      {srcWord1, srcWord0} > 32'h05f5e0ff |=> errorFlag && resWrite == 4'h0)
      else $error("32-bit source above limit not refused");
   area_err_a: assert property (go && opCode[2:1] == 2'h1 &&
      !(srcAreaSame && dstAreaSame) |=> errorFlag && resWrite == 4'h0)
      else $error("split time pair not refused");
   indirect_err_a: assert property (opStart && execCond &&
      indirectFault |=> errorFlag && resWrite == 4'h0)
      else $error("bad indirect operand not refused");
   onehot_word_a: assert property (go && opCode == 3'h4 &&
      !diBad && resultRoom > {1'b0, digitDesignator[5:4]} |=> resWrite[0] &&
      $onehot(resWord0) && !zeroFlag)
      else $error("decoder word not one-hot");
   designator_err_a: assert property (go && opCode == 3'h4 &&
      diBad |=> errorFlag && resWrite == 4'h0)
      else $error("bad designator not refused");
   word_hold_a: assert property ($changed(resWord0) |->
      resWrite[0])
      else $error("result word changed without write");
endmodule // wcd_monitor

bind wcd_datapath wcd_monitor u_mon (
   .core_clk(core_clk), .rst_n(rst_n), .opStart(opStart),
   .execCond(execCond), .opCode(opCode), .srcWord0(srcWord0),
   .srcWord1(srcWord1), .digitDesignator(digitDesignator),
   .srcAreaSame(srcAreaSame), .dstAreaSame(dstAreaSame),
   .resultRoom(resultRoom), .indirectFault(indirectFault),
   .opDone(opDone), .resWrite(resWrite), .resWord0(resWord0),
   .resWord1(resWord1), .resWord2(resWord2), .resWord3(resWord3),
   .errorFlag(errorFlag), .zeroFlag(zeroFlag));

/* sim/wcd_mem_model.sv */
// result data memory that keeps words handed over by the datapath
`timescale 1ns/1ps
module wcd_mem_model (
   input  wire        core_clk,
   input  wire        opDone,
   input  wire [3:0]  resWrite,
   input  wire [15:0] resWord0,
   input  wire [15:0] resWord1,
   input  wire [15:0] resWord2,
   input  wire [15:0] resWord3,
   output reg  [63:0] memBus
);
   initial memBus = 64'h0;
   // store each flagged word in the answer cycle only
   always @(posedge core_clk) begin
      if (opDone && resWrite[0])
         memBus[15:0] <= resWord0;
      if (opDone && resWrite[1])
         memBus[31:16] <= resWord1;
      if (opDone && resWrite[2])
         memBus[47:32] <= resWord2;
      if (opDone && resWrite[3])
         memBus[63:48] <= resWord3;
   end
endmodule // wcd_mem_model

/* sim/word_conversion_datapath_test.sv */
// self-checking bench of the word conversion datapath
`timescale 1ns/1ps
`include "wcd_defines.vh"
module word_conversion_datapath_test;
   reg         core_clk = 1'b0;
   reg         rst_n, opStart, execCond, srcAreaSame, dstAreaSame;
   reg         indirectFault;
   reg  [2:0]  opCode, resultRoom;
   reg  [15:0] srcWord0, srcWord1, digitDesignator, seed;
   reg  [15:0] expW [0:3];
   reg  [3:0]  expWr;
   reg         expErr, expZero;
   wire        opDone, errorFlag, zeroFlag;
   wire [3:0]  resWrite;
   wire [15:0] resWord0, resWord1, resWord2, resWord3;
   wire [63:0] memBus;
   integer     errorCnt, checked, n;
   reg  [15:0] a, b, c;

   always #5 core_clk = ~core_clk;

   wcd_datapath u_dut (.core_clk(core_clk), .rst_n(rst_n),
      .opStart(opStart), .execCond(execCond), .opCode(opCode),
      .srcWord0(srcWord0), .srcWord1(srcWord1),
      .digitDesignator(digitDesignator), .srcAreaSame(srcAreaSame),
      .dstAreaSame(dstAreaSame), .resultRoom(resultRoom),
      .indirectFault(indirectFault), .opDone(opDone),
      .resWrite(resWrite), .resWord0(resWord0), .resWord1(resWord1),
      .resWord2(resWord2), .resWord3(resWord3), .errorFlag(errorFlag),
      .zeroFlag(zeroFlag));
   wcd_mem_model u_mem (.core_clk(core_clk), .opDone(opDone),
      .resWrite(resWrite), .resWord0(resWord0), .resWord1(resWord1),
      .resWord2(resWord2), .resWord3(resWord3), .memBus(memBus));

   // random source for traffic and decimal helpers for expectations
   function logic [15:0] lfsr();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction
   function [31:0] toBcd(input integer v);
      for (int k = 0; k < 8; k++) begin
         toBcd[4*k +: 4] = v % 10;
         v = v / 10;
      end
   endfunction
   function integer fromBcd(input [31:0] d);
      fromBcd = 0;
      for (int k = 7; k >= 0; k--)
         fromBcd = fromBcd * 10 + d[4*k +: 4];
   endfunction
   function bit isBcd(input [31:0] d);
      isBcd = 1;
      for (int k = 0; k < 8; k++)
         if (d[4*k +: 4] > 4'h9)
            isBcd = 0;
   endfunction

   task cmp(input [15:0] g, e, input string m);
      checked = checked + 1;
      if (g !== e) begin
         errorCnt = errorCnt + 1;
         $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask
   task put(input [31:0] r, input [3:0] w);
      expW[0] = r[15:0];
      if (w[1])
         expW[1] = r[31:16];
      expWr = w;
      expZero = (r == 32'h0);
   endtask

   // one request: expectation first, then drive and compare
   task runOp(input [2:0] op, input [15:0] s0, s1 = 0, di = 0,
              input [2:0] rm = 4, input ec = 1, sa = 1, da = 1,
              flt = 0);
      integer v, i;
      expWr = 4'h0;
      v = fromBcd({s1, s0});
      if (ec && flt)
         expErr = 1'b1;
      else if (ec) begin
         case (op)
         `WCD_OP_BIN16: expErr = s0 > 16'h270f;
         `WCD_OP_BIN32: expErr = {s1, s0} > 32'h05f5e0ff;
         `WCD_OP_HMS2SEC: expErr = !(sa && da) || !isBcd({s1, s0}) ||
            s0[7:0] > 8'h59 || s0[15:8] > 8'h59;
         `WCD_OP_SEC2HMS: expErr = !(sa && da) || !isBcd({s1, s0}) ||
            v > 35999999;
         `WCD_OP_ONEHOT: expErr = di[3:0] > 3 || di[7:4] > 3 ||
            rm <= di[7:4];
         default: expErr = 1'b1;
         endcase
         if (!expErr && op == `WCD_OP_BIN16)
            put(toBcd(s0), 4'h1);
         if (!expErr && op == `WCD_OP_BIN32)
            put(toBcd({s1, s0}), 4'h3);
         if (!expErr && op == `WCD_OP_HMS2SEC)
            put(toBcd(fromBcd(s1) * 3600 + fromBcd(s0[15:8]) * 60 +
               fromBcd(s0[7:0])), 4'h3);
         if (!expErr && op == `WCD_OP_SEC2HMS)
            put((toBcd(v / 3600) << 16) | (toBcd(v / 60 % 60) << 8) |
               toBcd(v % 60), 4'h3);
         if (!expErr && op == `WCD_OP_ONEHOT) begin
            for (i = 0; i <= di[5:4]; i = i + 1) begin
               expW[i] = 16'h1 << ((s0 >> (4 * ((di[1:0] + i) % 4))) & 15);
               expWr[i] = 1'b1;
            end
            expZero = 1'b0;
         end
      end
      @(posedge core_clk);
      #1;
      {opStart, opCode, srcWord0, srcWord1, digitDesignator} =
         {1'b1, op, s0, s1, di};
      {resultRoom, execCond, srcAreaSame, dstAreaSame, indirectFault} =
         {rm, ec, sa, da, flt};
      @(posedge core_clk);
      #1;
      opStart = 1'b0;
      cmp(opDone, 1'b1, "done");
      cmp(resWrite, expWr, "write");
      cmp(errorFlag, expErr, "error");
      cmp(zeroFlag, expZero, "zero");
      @(posedge core_clk);
      #1;
      cmp({opDone, resWrite}, 5'h0, "strobe low");
      for (i = 0; i < 4; i = i + 1)
         cmp(memBus[16*i +: 16], expW[i], "word");
   endtask

   task wrapUp;
      $display("checks %0d mismatches %0d", checked, errorCnt);
      if (errorCnt == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // reset, corner cases, then random traffic
   initial begin
      {rst_n, opStart, execCond, srcAreaSame, dstAreaSame} = 5'h0;
      {indirectFault, opCode, resultRoom} = 7'h0;
      {srcWord0, srcWord1, digitDesignator} = 48'h0;
      {expW[0], expW[1], expW[2], expW[3]} = 64'h0;
      {expErr, expZero, errorCnt, checked, seed} = {2'b0, 64'h0, 16'h0030};
      repeat (3) @(posedge core_clk);
      #1 rst_n = 1'b1;
      repeat (2) @(posedge core_clk);
      runOp(`WCD_OP_BIN16, 16'h0000);
      runOp(`WCD_OP_BIN16, 16'h270f);
      runOp(`WCD_OP_BIN16, 16'h2710);
      runOp(`WCD_OP_BIN32, 16'he0ff, 16'h05f5);
      runOp(`WCD_OP_BIN32, 16'he100, 16'h05f5);
      runOp(`WCD_OP_HMS2SEC, 16'h5959, 16'h9999);
      runOp(`WCD_OP_HMS2SEC, 16'h6000, 16'h0001);
      runOp(`WCD_OP_HMS2SEC, 16'h000a, 16'h0001);
      runOp(`WCD_OP_HMS2SEC, 16'h0101, 16'h1, 0, 4, 1, 0);
      runOp(`WCD_OP_SEC2HMS, 16'h5927, 16'h1013);
      runOp(`WCD_OP_SEC2HMS, 16'h0000, 16'h3600);
      runOp(`WCD_OP_SEC2HMS, 16'h1, 16'h0, 0, 4, 1, 1, 0);
      runOp(`WCD_OP_ONEHOT, 16'h00f0, 0, 16'h0001, 1);
      runOp(`WCD_OP_ONEHOT, 16'hc640, 0, 16'h0033, 4);
      runOp(`WCD_OP_ONEHOT, 16'h1234, 0, 16'h0021, 2);
      runOp(`WCD_OP_ONEHOT, 16'h1234, 0, 16'h0004, 4);
      runOp(`WCD_OP_ONEHOT, 16'h1234, 0, 16'h0000, 4, 0);
      runOp(`WCD_OP_BIN16, 16'h0005, 0, 0, 4, 0);
      runOp(`WCD_OP_BIN16, 16'h5, 0, 0, 4, 1, 1, 1, 1);
      runOp(3'h5, 16'h0005);
      $display("corner cases done");
      for (n = 0; n < 250; n = n + 1) begin
         {a, b, c} = {lfsr(), lfsr(), lfsr()};
         case (n % 5)
         0: runOp(n % 5, a & 16'h3fff, b, 0, 4, |c[15:14]);
         1: runOp(n % 5, a, b & 16'h07ff, 0, 4, |c[15:14]);
         2: runOp(n % 5, toBcd(a % 60) | (toBcd(b % 60) << 8),
               toBcd(c % 10000), 0, 4, |c[15:14]);
         3: runOp(n % 5, toBcd({b, a} % 36000000),
               toBcd({b, a} % 36000000) >> 16, 0, 4, |c[15:14]);
         // designator digits kept within 0 to 3 by the issuer
         default: runOp(n % 5, a, 0, {10'h0, c[1:0], 2'h0, c[3:2]},
               c[12:10], |c[15:14]);
         endcase
      end
      $display("random run done");
      wrapUp;
   end
endmodule // word_conversion_datapath_test
